/* hdl/tws_pkg.sv */
/*
  Shared constants and state types for the two-wire slave and its bus master.
  Assumes a single 250 MHz system clock on both ends.
*/
package tws_pkg;
  // ----------------------------------------------------------------
  // Device register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] TWS_IDX_OWN = 8'h20;
  localparam logic [7:0] TWS_IDX_CTRL = 8'h21;
  localparam logic [7:0] TWS_IDX_STAT = 8'h22;
  localparam logic [7:0] TWS_IDX_DATA = 8'h23;
  localparam logic [7:0] TWS_RST_BYTE = 8'h00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TWS_CTL_EN = 7;
  localparam int TWS_CTL_TX = 4;
  localparam int TWS_CTL_ACK = 3;
  localparam int TWS_ST_CF = 7;
  localparam int TWS_ST_AAS = 6;
  localparam int TWS_ST_BB = 5;
  localparam int TWS_ST_RW = 2;
  localparam int TWS_ST_ACK_RECEIVED_FLAG = 0;
  // ----------------------------------------------------------------
  // Master controller registers and commands
  // ----------------------------------------------------------------
  localparam logic [3:0] TWS_M_CMD = 4'h0;
  localparam logic [3:0] TWS_M_DATA = 4'h4;
  localparam logic [3:0] TWS_M_STAT = 4'h8;
  localparam logic [2:0] TWS_C_START = 3'h1;
  localparam logic [2:0] TWS_C_WRITE = 3'h2;
  localparam logic [2:0] TWS_C_READ = 3'h3;
  localparam logic [2:0] TWS_C_STOP = 3'h4;
  localparam int TWS_C_ACK = 3;
  localparam int TWS_MS_BUSY = 0;
  localparam int TWS_MS_NACK = 1;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int TWS_CLK_NS = 4;
  localparam int TWS_HALF_NS = 64;
  localparam logic [4:0] TWS_HALF_CYC = 5'((TWS_HALF_NS + TWS_CLK_NS - 1) / TWS_CLK_NS);
  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_ADDR = 3'b001, D_ACKO = 3'b010, D_HOLD = 3'b011,
    D_RX = 3'b100, D_TX = 3'b101, D_ACKI = 3'b110, D_SKIP = 3'b111
  } tws_dst_t;
  typedef enum logic [2:0] {
    M_IDLE = 3'b000, M_START = 3'b001, M_LO = 3'b010, M_HI = 3'b011, M_STOP = 3'b100
  } tws_mst_t;
endpackage : tws_pkg

/* hdl/tws_if.sv */
/*
  Two-wire link between the slave device and the bus master.
  Resolves the open-drain wires: a line is low while any end enables a low drive.
*/
`timescale 1ns/100ps
interface tws_if;
  logic scl;
  logic sda;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic mst_scl_o;
  logic mst_scl_oe;
  logic mst_sda_o;
  logic mst_sda_oe;
  // Pull-up wins when nobody drives; ends only ever drive low
  assign scl = !((dev_scl_oe && !dev_scl_o) || (mst_scl_oe && !mst_scl_o));
  assign sda = !((dev_sda_oe && !dev_sda_o) || (mst_sda_oe && !mst_sda_o));
  modport dev (input scl, input sda, output dev_scl_o, output dev_scl_oe,
               output dev_sda_o, output dev_sda_oe);
  modport mst (input scl, input sda, output mst_scl_o, output mst_scl_oe,
               output mst_sda_o, output mst_sda_oe);
endinterface : tws_if

/* hdl/tws_slave.sv */
/*
  Slave end of the two-wire interface with its four byte registers on Avalon-MM.
  Assumes a master on the link that honours clock stretching.
*/
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/100ps
module tws_slave (
  // Clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // Two-wire link
  tws_if.dev BUS,
  // Avalon-MM register port
  input wire logic [9:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Interrupt request pulse
  output logic IRQ_REQ
);
  function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
    return a == {idx, 2'b00};
  endfunction : hit

  // ----------------------------------------------------------------
  // Link synchronisers and condition detect
  // ----------------------------------------------------------------
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'b111;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'b111;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {BUS.scl, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {BUS.sda, sda_m_q, sda_s_q};
    end
  end
  logic start_c, stop_c, rise_c, fall_c;
  assign start_c = scl_s_q && scl_p_q && !sda_s_q && sda_p_q;
  assign stop_c = scl_s_q && scl_p_q && sda_s_q && !sda_p_q;
  assign rise_c = scl_s_q && !scl_p_q;
  assign fall_c = !scl_s_q && scl_p_q;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  logic waitreq_q, done, wr_own, wr_ctl, wr_dat, rd_dat;
  logic [7:0] own_q, ctl_q, dat_q, stat;
  logic [31:0] rdata_q;
  logic cf_q, aas_q, bb_q, rw_q, ack_received_flag_q, irq_q;
  assign done = (AVS_READ || AVS_WRITE) && !waitreq_q;
  assign wr_own = done && AVS_WRITE && hit(AVS_ADDRESS, tws_pkg::TWS_IDX_OWN);
  assign wr_ctl = done && AVS_WRITE && hit(AVS_ADDRESS, tws_pkg::TWS_IDX_CTRL);
  assign wr_dat = done && AVS_WRITE && hit(AVS_ADDRESS, tws_pkg::TWS_IDX_DATA);
  assign rd_dat = done && AVS_READ && hit(AVS_ADDRESS, tws_pkg::TWS_IDX_DATA);
  always_comb begin
    stat = 8'h00;
    stat[tws_pkg::TWS_ST_CF] = cf_q;
    stat[tws_pkg::TWS_ST_AAS] = aas_q;
    stat[tws_pkg::TWS_ST_BB] = bb_q;
    stat[tws_pkg::TWS_ST_RW] = rw_q;
    stat[tws_pkg::TWS_ST_ACK_RECEIVED_FLAG] = ack_received_flag_q;
  end
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      waitreq_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      // One wait cycle per access; data is sampled while the request waits
      waitreq_q <= !((AVS_READ || AVS_WRITE) && waitreq_q);
      rdata_q <= 32'h0;
      if (AVS_READ && waitreq_q) begin
        if (hit(AVS_ADDRESS, tws_pkg::TWS_IDX_OWN)) rdata_q <= {24'h0, own_q};
        else if (hit(AVS_ADDRESS, tws_pkg::TWS_IDX_CTRL)) rdata_q <= {24'h0, ctl_q};
        else if (hit(AVS_ADDRESS, tws_pkg::TWS_IDX_STAT)) rdata_q <= {24'h0, stat};
        else if (hit(AVS_ADDRESS, tws_pkg::TWS_IDX_DATA)) rdata_q <= {24'h0, dat_q};
      end
    end
  end
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      own_q <= tws_pkg::TWS_RST_BYTE;
      ctl_q <= tws_pkg::TWS_RST_BYTE;
    end else begin
      if (wr_own) own_q <= {AVS_WRITEDATA[7:1], 1'b0};
      // Unused control bits are not stored
      if (wr_ctl) ctl_q <= AVS_WRITEDATA[7:0] & 8'h98;
    end
  end
  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = waitreq_q;
  assign IRQ_REQ = irq_q;

  // ----------------------------------------------------------------
  // Bus busy flag
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) bb_q <= 1'b0;
    else if (start_c) bb_q <= 1'b1;
    else if (stop_c) bb_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  tws_pkg::tws_dst_t st_q;
  logic [7:0] sh_q, byte_in;
  logic [2:0] cnt_q;
  logic ph_q, scl_oe_q, sda_oe_q, set_aas, clr_aas, adr_q;
  logic en, tx;
  assign en = ctl_q[tws_pkg::TWS_CTL_EN];
  assign tx = ctl_q[tws_pkg::TWS_CTL_TX];
  assign byte_in = {sh_q[6:0], sda_s_q};
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= tws_pkg::D_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 3'h0;
      ph_q <= 1'b0;
      adr_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      dat_q <= tws_pkg::TWS_RST_BYTE;
      cf_q <= 1'b0;
      rw_q <= 1'b0;
      ack_received_flag_q <= 1'b0;
      irq_q <= 1'b0;
      set_aas <= 1'b0;
      clr_aas <= 1'b0;
    end else begin
      irq_q <= 1'b0;
      set_aas <= 1'b0;
      clr_aas <= 1'b0;
      if (wr_dat) dat_q <= AVS_WRITEDATA[7:0];
      if (!en) begin
        st_q <= tws_pkg::D_IDLE;
        scl_oe_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (start_c) begin
        st_q <= tws_pkg::D_ADDR;
        cnt_q <= 3'h0;
        scl_oe_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (stop_c) begin
        st_q <= tws_pkg::D_IDLE;
        scl_oe_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end else begin
        unique case (st_q)
          tws_pkg::D_IDLE, tws_pkg::D_SKIP: begin
            sda_oe_q <= 1'b0;
          end
          tws_pkg::D_ADDR: if (rise_c) begin
            sh_q <= byte_in;
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              if (byte_in[7:1] == own_q[7:1]) begin
                set_aas <= 1'b1;
                irq_q <= 1'b1;
                cf_q <= 1'b1;
                rw_q <= byte_in[0];
                adr_q <= 1'b1;
                ph_q <= 1'b0;
                st_q <= tws_pkg::D_ACKO;
              end else begin
                clr_aas <= 1'b1;
                st_q <= tws_pkg::D_SKIP;
              end
            end
          end
          tws_pkg::D_ACKO: if (fall_c) begin
            if (!ph_q) begin
              // Address ack is unconditional; data ack follows control bit 3
              sda_oe_q <= adr_q || !ctl_q[tws_pkg::TWS_CTL_ACK];
              ph_q <= 1'b1;
            end else begin
              sda_oe_q <= 1'b0;
              scl_oe_q <= 1'b1;
              st_q <= tws_pkg::D_HOLD;
            end
          end
          tws_pkg::D_HOLD: begin
            if (tx && wr_dat) begin
              cf_q <= 1'b0;
              sh_q <= AVS_WRITEDATA[7:0];
              sda_oe_q <= !AVS_WRITEDATA[7];
              scl_oe_q <= 1'b0;
              cnt_q <= 3'h0;
              st_q <= tws_pkg::D_TX;
            end else if (!tx && rd_dat) begin
              cf_q <= 1'b0;
              scl_oe_q <= 1'b0;
              cnt_q <= 3'h0;
              st_q <= tws_pkg::D_RX;
            end
          end
          tws_pkg::D_RX: if (rise_c) begin
            sh_q <= byte_in;
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              dat_q <= byte_in;
              adr_q <= 1'b0;
              cf_q <= 1'b1;
              irq_q <= 1'b1;
              ph_q <= 1'b0;
              st_q <= tws_pkg::D_ACKO;
            end
          end
          tws_pkg::D_TX: if (fall_c) begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              sda_oe_q <= 1'b0;
              st_q <= tws_pkg::D_ACKI;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              sda_oe_q <= !sh_q[6];
            end
          end
          tws_pkg::D_ACKI: begin
            if (rise_c) ack_received_flag_q <= sda_s_q;
            if (fall_c) begin
              cf_q <= 1'b1;
              irq_q <= 1'b1;
              scl_oe_q <= 1'b1;
              st_q <= tws_pkg::D_HOLD;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Address-matched flag; a match in the clearing cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) aas_q <= 1'b0;
    else if (set_aas) aas_q <= 1'b1;
    else if (wr_ctl || clr_aas) aas_q <= 1'b0;
  end

  assign BUS.dev_scl_o = 1'b0;
  assign BUS.dev_sda_o = 1'b0;
  assign BUS.dev_scl_oe = scl_oe_q;
  assign BUS.dev_sda_oe = sda_oe_q;
endmodule : tws_slave

/* hdl/tws_master.sv */
/*
  Bus master end: issues START, byte write, byte read and STOP on command.
  Assumes the slave may stretch the clock; the master waits for it.
*/
`timescale 1ns/100ps
module tws_master (
  // Clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // Two-wire link
  tws_if.mst BUS,
  // Avalon-MM register port
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);
  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic scl_m_q, scl_s_q, sda_m_q, sda_s_q;
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) {scl_m_q, scl_s_q, sda_m_q, sda_s_q} <= 4'hF;
    else {scl_m_q, scl_s_q, sda_m_q, sda_s_q} <= {BUS.scl, scl_m_q, BUS.sda, sda_m_q};
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  tws_pkg::tws_mst_t st_q;
  logic waitreq_q, done, cmd_go;
  logic [7:0] txd_q;
  logic [8:0] rx_q, sh_q;
  logic [31:0] rdata_q;
  assign done = (AVS_READ || AVS_WRITE) && !waitreq_q;
  // Commands while busy are dropped; poll the busy bit first
  assign cmd_go = done && AVS_WRITE && AVS_ADDRESS == tws_pkg::TWS_M_CMD
                  && st_q == tws_pkg::M_IDLE;
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      waitreq_q <= 1'b1;
      rdata_q <= 32'h0;
      txd_q <= 8'h00;
    end else begin
      waitreq_q <= !((AVS_READ || AVS_WRITE) && waitreq_q);
      rdata_q <= 32'h0;
      if (AVS_READ && waitreq_q) begin
        if (AVS_ADDRESS == tws_pkg::TWS_M_DATA) rdata_q <= {24'h0, rx_q[8:1]};
        else if (AVS_ADDRESS == tws_pkg::TWS_M_STAT)
          rdata_q <= {30'h0, rx_q[0], st_q != tws_pkg::M_IDLE};
      end
      if (done && AVS_WRITE && AVS_ADDRESS == tws_pkg::TWS_M_DATA)
        txd_q <= AVS_WRITEDATA[7:0];
    end
  end
  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = waitreq_q;

  // ----------------------------------------------------------------
  // Bit engine; the clock is a divider, half period per phase
  // ----------------------------------------------------------------
  logic [4:0] tmr_q;
  logic [1:0] step_q;
  logic [3:0] cnt_q;
  logic scl_oe_q, sda_oe_q, tz;
  assign tz = tmr_q == 5'h0;
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= tws_pkg::M_IDLE;
      tmr_q <= 5'h0;
      step_q <= 2'h0;
      cnt_q <= 4'h0;
      sh_q <= 9'h1FF;
      rx_q <= 9'h000;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      if (!tz) tmr_q <= tmr_q - 5'h1;
      unique case (st_q)
        tws_pkg::M_IDLE: if (cmd_go) begin
          tmr_q <= tws_pkg::TWS_HALF_CYC;
          step_q <= 2'h0;
          cnt_q <= 4'h0;
          if (AVS_WRITEDATA[2:0] == tws_pkg::TWS_C_START) begin
            sh_q <= {txd_q, 1'b1};
            st_q <= tws_pkg::M_START;
          end else if (AVS_WRITEDATA[2:0] == tws_pkg::TWS_C_WRITE) begin
            sh_q <= {txd_q, 1'b1};
            st_q <= tws_pkg::M_LO;
          end else if (AVS_WRITEDATA[2:0] == tws_pkg::TWS_C_READ) begin
            sh_q <= {8'hFF, AVS_WRITEDATA[tws_pkg::TWS_C_ACK]};
            st_q <= tws_pkg::M_LO;
          end else if (AVS_WRITEDATA[2:0] == tws_pkg::TWS_C_STOP) begin
            st_q <= tws_pkg::M_STOP;
          end
        end
        tws_pkg::M_START: if (tz && (step_q != 2'h2 || scl_s_q)) begin
          tmr_q <= tws_pkg::TWS_HALF_CYC;
          step_q <= step_q + 2'h1;
          unique case (step_q)
            2'h0: sda_oe_q <= 1'b0;
            2'h1: scl_oe_q <= 1'b0;
            2'h2: sda_oe_q <= 1'b1;
            2'h3: begin
              scl_oe_q <= 1'b1;
              st_q <= tws_pkg::M_LO;
            end
          endcase
        end
        tws_pkg::M_LO: begin
          // Data moves one cycle after the clock fell, never with it
          sda_oe_q <= !sh_q[8];
          if (tz) begin
            scl_oe_q <= 1'b0;
            tmr_q <= tws_pkg::TWS_HALF_CYC;
            st_q <= tws_pkg::M_HI;
          end
        end
        tws_pkg::M_HI: begin
          if (!scl_s_q) tmr_q <= tws_pkg::TWS_HALF_CYC;
          else if (tz) begin
            rx_q <= {rx_q[7:0], sda_s_q};
            scl_oe_q <= 1'b1;
            tmr_q <= tws_pkg::TWS_HALF_CYC;
            cnt_q <= cnt_q + 4'h1;
            sh_q <= {sh_q[7:0], 1'b1};
            st_q <= (cnt_q == 4'h8) ? tws_pkg::M_IDLE : tws_pkg::M_LO;
          end
        end
        tws_pkg::M_STOP: if (tz && (step_q != 2'h2 || scl_s_q)) begin
          tmr_q <= tws_pkg::TWS_HALF_CYC;
          step_q <= step_q + 2'h1;
          unique case (step_q)
            2'h0: sda_oe_q <= 1'b1;
            2'h1: scl_oe_q <= 1'b0;
            2'h2: sda_oe_q <= 1'b0;
            2'h3: st_q <= tws_pkg::M_IDLE;
          endcase
        end
        default: st_q <= tws_pkg::M_IDLE;
      endcase
    end
  end
  assign BUS.mst_scl_o = 1'b0;
  assign BUS.mst_sda_o = 1'b0;
  assign BUS.mst_scl_oe = scl_oe_q;
  assign BUS.mst_sda_oe = sda_oe_q;
endmodule : tws_master

/* test/tws_sva.sv */
/*
  Wire checker for the two-wire link between slave and master.
  Assumes both ends run from MCLK and drive the link from registers.
*/
`timescale 1ns/100ps
module tws_sva (
  // Clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // Resolved wires
  input wire logic scl,
  input wire logic sda,
  // Slave drives
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  // Master drives
  input wire logic mst_scl_o,
  input wire logic mst_scl_oe,
  input wire logic mst_sda_o,
  input wire logic mst_sda_oe
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  // ----------------------------------------------------------------
  // Frame tracking
  // ----------------------------------------------------------------
  logic scl_q, sda_q, busy_q, first_q, start_ev, stop_ev, rise_ev;
  logic [3:0] bit_q;
  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev = scl && scl_q && !sda_q && sda;
  assign rise_ev = scl && !scl_q;
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) busy_q <= 1'b0;
    else if (start_ev) busy_q <= 1'b1;
    else if (stop_ev) busy_q <= 1'b0;
  end
  // Count wraps 9 to 1 so the first byte flag drops on the next byte's first rise
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bit_q <= 4'h0;
      first_q <= 1'b0;
    end else if (start_ev) begin
      bit_q <= 4'h0;
      first_q <= 1'b1;
    end else if (rise_ev) begin
      bit_q <= (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
      if (bit_q == 4'h9) first_q <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_low_only;
    !dev_scl_o && !dev_sda_o && !mst_scl_o && !mst_sda_o;
  endproperty
  a_low_only: assert property (p_low_only) else $error("line driven high");
  property p_rst_free;
    $rose(ARST_N) |-> !dev_scl_oe && !dev_sda_oe && !mst_scl_oe && !mst_sda_oe;
  endproperty
  a_rst_free: assert property (p_rst_free) else $error("line held after reset");
  property p_stretch_only;
    $rose(dev_scl_oe) |-> !$past(scl, 1) && !$past(scl, 2);
  endproperty
  a_stretch_only: assert property (p_stretch_only) else $error("slave made a clock");
  property p_start_by_mst;
    ($fell(sda) && scl && $past(scl)) |-> mst_sda_oe;
  endproperty
  a_start_by_mst: assert property (p_start_by_mst) else $error("slave made a start");
  property p_sda_steady;
    (scl && scl_q) |-> $stable(dev_sda_oe);
  endproperty
  a_sda_steady: assert property (p_sda_steady) else $error("slave data moved");
  property p_idle_free;
    !busy_q |-> !dev_sda_oe && !dev_scl_oe;
  endproperty
  a_idle_free: assert property (p_idle_free) else $error("slave drives idle bus");
  property p_addr_quiet;
    (first_q && scl && scl_q && bit_q >= 4'h1 && bit_q <= 4'h8) |-> !dev_sda_oe;
  endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("slave drove address");
  property p_one_talker;
    (scl && dev_sda_oe) |-> !mst_sda_oe ##1 (!scl || !mst_sda_oe);
  endproperty
  a_one_talker: assert property (p_one_talker) else $error("both ends drive data");
endmodule : tws_sva

/* test/tws_tb.sv */
/*
  Self-checking bench: slave and master joined through the two-wire link.
  Assumes one wait cycle on both Avalon ports and a master that stalls on a held clock.
*/
`timescale 1ns/100ps
module tb;
  localparam logic [9:0] D_OWN = {tws_pkg::TWS_IDX_OWN, 2'b00};
  localparam logic [9:0] D_CTL = {tws_pkg::TWS_IDX_CTRL, 2'b00};
  localparam logic [9:0] D_STA = {tws_pkg::TWS_IDX_STAT, 2'b00};
  localparam logic [9:0] D_DAT = {tws_pkg::TWS_IDX_DATA, 2'b00};
  localparam logic [9:0] M_CMD = {6'h00, tws_pkg::TWS_M_CMD};
  localparam logic [9:0] M_DAT = {6'h00, tws_pkg::TWS_M_DATA};
  localparam logic [9:0] M_STA = {6'h00, tws_pkg::TWS_M_STAT};
  logic MCLK, ARST_N, s_rd, s_wr, s_wait, irq, m_rd, m_wr, m_wait;
  logic [9:0] s_addr;
  logic [3:0] m_addr;
  logic [31:0] s_wdata, s_rdata, m_wdata, m_rdata;
  logic [15:0] note_q[$];
  logic [15:0] nt;
  logic [7:0] last_rd, irq_cnt, d0, d1;
  logic [6:0] own;
  int error_cnt, samples_checked, seed;
  tws_if u_tws_if();
  tws_slave u_tws_slave(.MCLK(MCLK), .ARST_N(ARST_N), .BUS(u_tws_if.dev),
    .AVS_ADDRESS(s_addr), .AVS_READ(s_rd), .AVS_WRITE(s_wr), .AVS_WRITEDATA(s_wdata),
    .AVS_READDATA(s_rdata), .AVS_WAITREQUEST(s_wait), .IRQ_REQ(irq));
  tws_master u_tws_master(.MCLK(MCLK), .ARST_N(ARST_N), .BUS(u_tws_if.mst),
    .AVS_ADDRESS(m_addr), .AVS_READ(m_rd), .AVS_WRITE(m_wr), .AVS_WRITEDATA(m_wdata),
    .AVS_READDATA(m_rdata), .AVS_WAITREQUEST(m_wait));
  tws_sva u_tws_sva(.MCLK(MCLK), .ARST_N(ARST_N), .scl(u_tws_if.scl), .sda(u_tws_if.sda),
    .dev_scl_o(u_tws_if.dev_scl_o), .dev_scl_oe(u_tws_if.dev_scl_oe),
    .dev_sda_o(u_tws_if.dev_sda_o), .dev_sda_oe(u_tws_if.dev_sda_oe),
    .mst_scl_o(u_tws_if.mst_scl_o), .mst_scl_oe(u_tws_if.mst_scl_oe),
    .mst_sda_o(u_tws_if.mst_sda_o), .mst_sda_oe(u_tws_if.mst_sda_oe));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checked %0d, unexpected %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic stall();
    error_cnt++;
    $display("unexpected at %0t: wait ran out", $time);
    tally_and_finish();
  endtask : stall
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, wanted %h", $time, seen, want);
    end
  endtask : check
  // Request held until waitrequest is seen low; a zero mask makes the read a plain poll
  task automatic ac(input int dv, input int wr, input logic [9:0] a, input logic [7:0] d,
                    input logic [7:0] mk, input logic [7:0] ex);
    int n;
    n = 0;
    @(posedge MCLK);
    if (!wr) note_q.push_back({mk, ex});
    if (dv) begin
      s_addr <= a;
      s_rd <= !wr;
      s_wr <= wr;
      s_wdata <= {24'h000000, d};
    end else begin
      m_addr <= a[3:0];
      m_rd <= !wr;
      m_wr <= wr;
      m_wdata <= {24'h000000, d};
    end
    do begin
      @(posedge MCLK);
      n++;
    end while ((dv ? s_wait : m_wait) !== 1'b0 && n < 100);
    last_rd = dv ? s_rdata[7:0] : m_rdata[7:0];
    if (n >= 100) stall();
    s_rd <= 1'b0;
    s_wr <= 1'b0;
    m_rd <= 1'b0;
    m_wr <= 1'b0;
  endtask : ac
  task automatic mcmd(input logic [7:0] cmd, input logic [7:0] d);
    int n;
    n = 0;
    ac(0, 1, M_DAT, d, 8'h00, 8'h00);
    ac(0, 1, M_CMD, cmd, 8'h00, 8'h00);
    do begin
      ac(0, 0, M_STA, 8'h00, 8'h00, 8'h00);
      n++;
    end while (last_rd[tws_pkg::TWS_MS_BUSY] !== 1'b0 && n < 1000);
    if (n >= 1000) stall();
  endtask : mcmd
  // ----------------------------------------------------------------
  // Clock, result watcher and stimulus
  // ----------------------------------------------------------------
  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end
  always @(posedge MCLK) begin
    if (irq === 1'b1) irq_cnt <= irq_cnt + 8'h01;
    if ((s_rd === 1'b1 && s_wait === 1'b0) || (m_rd === 1'b1 && m_wait === 1'b0)) begin
      nt = note_q.pop_front();
      if (nt[15:8] != 8'h00) check((s_rd ? s_rdata[7:0] : m_rdata[7:0]) & nt[15:8], nt[7:0]);
    end
  end
  initial begin
    seed = 32'hC1C51986;
    own = 7'($random(seed));
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    {s_rd, s_wr, m_rd, m_wr, s_addr, m_addr, s_wdata, m_wdata} = '0;
    irq_cnt = 8'h00;
    ARST_N = 1'b0;
    repeat (2) @(posedge MCLK);
    ARST_N <= 1'b1;
    ac(1, 0, D_STA, 8'h00, 8'hFF, 8'h00);
    ac(1, 1, D_OWN, {own, 1'b1}, 8'h00, 8'h00);
    ac(1, 0, D_OWN, 8'h00, 8'hFF, {own, 1'b0});
    ac(1, 1, D_CTL, 8'hFF, 8'h00, 8'h00);
    ac(1, 0, D_CTL, 8'h00, 8'hFF, 8'h98);
    ac(1, 0, 10'h090, 8'h00, 8'hFF, 8'h00);
    ac(1, 1, D_CTL, 8'h80, 8'h00, 8'h00);
    $display("test registers done");
    mcmd(8'h01, {own, 1'b0});
    ac(0, 0, M_STA, 8'h00, 8'h02, 8'h00);
    ac(1, 0, D_STA, 8'h00, 8'hFF, 8'hE0);
    ac(1, 0, D_DAT, 8'h00, 8'h00, 8'h00);
    mcmd(8'h02, d0);
    ac(0, 0, M_STA, 8'h00, 8'h02, 8'h00);
    ac(1, 0, D_STA, 8'h00, 8'h80, 8'h80);
    ac(1, 0, D_DAT, 8'h00, 8'hFF, d0);
    ac(1, 1, D_CTL, 8'h88, 8'h00, 8'h00);
    ac(1, 0, D_STA, 8'h00, 8'h40, 8'h00);
    mcmd(8'h02, d1);
    ac(0, 0, M_STA, 8'h00, 8'h02, 8'h02);
    ac(1, 0, D_DAT, 8'h00, 8'hFF, d1);
    ac(1, 0, D_STA, 8'h00, 8'h80, 8'h00);
    mcmd(8'h04, 8'h00);
    ac(1, 0, D_STA, 8'h00, 8'h20, 8'h00);
    $display("test slave receive done");
    ac(1, 1, D_CTL, 8'h80, 8'h00, 8'h00);
    mcmd(8'h01, {own, 1'b1});
    ac(1, 0, D_STA, 8'h00, 8'h44, 8'h44);
    ac(1, 1, D_CTL, 8'h90, 8'h00, 8'h00);
    ac(1, 1, D_DAT, d0, 8'h00, 8'h00);
    mcmd(8'h03, 8'h00);
    ac(0, 0, M_DAT, 8'h00, 8'hFF, d0);
    ac(1, 0, D_STA, 8'h00, 8'h81, 8'h80);
    ac(1, 1, D_DAT, d1, 8'h00, 8'h00);
    mcmd(8'h0B, 8'h00);
    ac(0, 0, M_DAT, 8'h00, 8'hFF, d1);
    ac(1, 0, D_STA, 8'h00, 8'h01, 8'h01);
    ac(1, 1, D_CTL, 8'h80, 8'h00, 8'h00);
    ac(1, 0, D_DAT, 8'h00, 8'h00, 8'h00);
    mcmd(8'h04, 8'h00);
    $display("test slave transmit done");
    mcmd(8'h01, {own ^ 7'h01, 1'b0});
    ac(0, 0, M_STA, 8'h00, 8'h02, 8'h02);
    ac(1, 0, D_STA, 8'h00, 8'h40, 8'h00);
    mcmd(8'h04, 8'h00);
    ac(1, 1, D_CTL, 8'h00, 8'h00, 8'h00);
    mcmd(8'h01, {own, 1'b0});
    ac(0, 0, M_STA, 8'h00, 8'h02, 8'h02);
    mcmd(8'h04, 8'h00);
    check(irq_cnt, 8'h06);
    $display("test refusals done");
    tally_and_finish();
  end
endmodule : tb
